// file: shared/ccti_pkg.sv
// constants and carrier types for the crystal clock timer
// assumes a 4-bit cpu data memory port with 8-bit i/o addresses
package ccti_pkg;
  // i/o locations
  localparam logic [7:0] FLAGS_ADDR = 8'hc4;
  localparam logic [7:0] ENABLES_ADDR = 8'hd1;
  localparam logic [7:0] SOFT_RESET_ADDR = 8'hd9;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'hda;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'hdb;
  // data nibble width and reset values
  localparam int DATA_W = 4;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] ENABLES_RESET = 4'h0;
  localparam logic [3:0] READ_ZERO = 4'h0;
  // bit positions in flag and enable locations
  localparam int BIT_32HZ = 0;
  localparam int BIT_16HZ = 1;
  localparam int BIT_2HZ = 2;
  localparam int BIT_1HZ = 3;
  // soft reset bit
  localparam int SOFT_RESET_BIT = 0;
  // divider: bit k of the chain runs at crystal / 2^(k+1)
  localparam int PRESCALE_BITS = 7;
  localparam int STAGE_COUNT = 8;
  // stage indices within the eight observable stages
  localparam int STAGE_32HZ = 2;
  localparam int STAGE_16HZ = 3;
  localparam int STAGE_2HZ = 6;
  localparam int STAGE_1HZ = 7;
  localparam logic [1:0] ARMED_CLEAR = 2'h0;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] wdata;
  } ccti_bus_req_type;
endpackage

// file: rtl/ccti_divider.sv
// binary divider chain stepped by the slow crystal clock
// assumes the crystal level arrives synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module ccti_divider #(
  parameter int PRESCALE_BITS = ccti_pkg::PRESCALE_BITS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_crystal_clock_in,
  input wire logic soft_reset_in,
  output logic [7:0] stages_out,
  output logic [3:0] falls_out
);
  localparam int CNT_W = PRESCALE_BITS + ccti_pkg::STAGE_COUNT;
  logic xtal_prev_q;
  logic tick;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] stage_prev_q;
  logic [1:0] armed_q;
  logic [7:0] fall_all;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xtal_prev_q <= 1'b0;
    end else begin
      xtal_prev_q <= slow_crystal_clock_in;
    end
  end
  assign tick = slow_crystal_clock_in & ~xtal_prev_q;

  // no system reset here: only counting and the soft reset move the chain
  always_ff @(posedge clk_in) begin
    if (soft_reset_in) begin
      cnt_q <= '0; // RULE4
    end else if (tick) begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE1
    end
  end

  always_ff @(posedge clk_in) begin
    stage_prev_q <= stages_out;
  end

  // edges are trusted only once the chain holds a known value
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_q <= ccti_pkg::ARMED_CLEAR;
    end else begin
      armed_q <= {armed_q[1] | armed_q[0], armed_q[0] | soft_reset_in}; // RULE6 RULE13
    end
  end

  assign stages_out = cnt_q[CNT_W-1:PRESCALE_BITS]; // RULE1
  assign fall_all = stage_prev_q & ~stages_out;
  always_comb begin
    falls_out = '0;
    if (armed_q[1]) begin
      falls_out[ccti_pkg::BIT_32HZ] = fall_all[ccti_pkg::STAGE_32HZ]; // RULE7
      falls_out[ccti_pkg::BIT_16HZ] = fall_all[ccti_pkg::STAGE_16HZ]; // RULE7
      falls_out[ccti_pkg::BIT_2HZ] = fall_all[ccti_pkg::STAGE_2HZ]; // RULE7
      falls_out[ccti_pkg::BIT_1HZ] = fall_all[ccti_pkg::STAGE_1HZ]; // RULE7
    end
  end

  AST_SOFT_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    soft_reset_in |=> (cnt_q == '0)) // RULE4
    else $error("soft reset did not clear the chain");
  AST_COUNT_STEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (armed_q[1] && tick && !soft_reset_in) |=>
    (cnt_q == $past(cnt_q) + {{(CNT_W-1){1'b0}}, 1'b1})) // RULE1
    else $error("chain did not advance on a crystal edge");
  AST_COUNT_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (armed_q[1] && !tick && !soft_reset_in) |=> $stable(cnt_q)) // RULE6
    else $error("chain moved without a crystal edge");
endmodule
`default_nettype wire

// file: rtl/ccti_timer.sv
// crystal clock timer: divider stages, interrupt flags, enables and reads
// assumes one-cycle rd/wr strobes on the cpu i/o port, synchronous to clk_in
// Function
// RULE1: chain advances on slow crystal edges, stages 128 Hz down to 1 Hz.
// RULE2: low nibble reads 128, 64, 32, 16 Hz stages on bits 0 to 3.
// RULE3: high nibble reads 8, 4, 2, 1 Hz stages on bits 0 to 3.
// RULE4: writing one to reset bit zero clears the chain; zero does nothing.
// RULE5: reset bit and unused bits always read as zero.
// RULE6: system reset leaves the chain alone; only counting or soft reset change it.
// RULE7: falling edge of 32, 16, 2, 1 Hz stages sets its flag; the code ignores these edges until a soft reset follows the last system reset.
// RULE8: flags set regardless of enables; enables gate only the request.
// RULE9: 2, 16, 32 Hz flags read-only, start zero, cleared by reading.
// RULE10: 1 Hz flag sits on bit 3; others on bits 2, 1, 0.
// RULE11: enable location is read/write, one enables, all zero after reset.
// RULE12: 32 Hz enable resets to zero and is read/write.
// RULE13: soft reset may leave a flag set; software reads flags afterwards.
// RULE14: software reads high nibble within 0.5 ms after the low nibble.
// RULE15: software writes enables only with cpu interrupts disabled.
// RULE16: software reads flags with cpu interrupts disabled.
// RULE17: a flag set during its clearing read survives to the next read.
// RULE18: interrupt request is high while any flag and its enable are one.
`timescale 1ns/1ps
`default_nettype none
module ccti_timer #(
  parameter int PRESCALE_BITS = ccti_pkg::PRESCALE_BITS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_crystal_clock_in,
  input wire ccti_pkg::ccti_bus_req_type bus_in,
  output logic [3:0] rdata_out,
  output logic rvalid_out,
  output logic irq_out
);
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [3:0] enables_q;
  logic [3:0] rdata_q;
  logic rvalid_q;
  logic irq_q;
  logic [7:0] stages;
  logic [3:0] falls;
  logic soft_reset;
  logic rd_flags;
  logic wr_enables;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] loc);
    hit = (addr == loc);
  endfunction

  assign soft_reset = bus_in.wr & hit(bus_in.addr, ccti_pkg::SOFT_RESET_ADDR) &
                      bus_in.wdata[ccti_pkg::SOFT_RESET_BIT]; // RULE4
  assign rd_flags = bus_in.rd & hit(bus_in.addr, ccti_pkg::FLAGS_ADDR);
  assign wr_enables = bus_in.wr & hit(bus_in.addr, ccti_pkg::ENABLES_ADDR);

  ccti_divider #(
    .PRESCALE_BITS(PRESCALE_BITS)
  ) u_divider (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .slow_crystal_clock_in(slow_crystal_clock_in),
    .soft_reset_in(soft_reset),
    .stages_out(stages),
    .falls_out(falls)
  );

  // set wins over the clearing read
  assign flags_d = (flags_q & ~{4{rd_flags}}) | falls; // RULE9 RULE17 RULE8

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_q <= ccti_pkg::FLAGS_RESET; // RULE9
    end else begin
      flags_q <= flags_d; // RULE7 RULE10
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enables_q <= ccti_pkg::ENABLES_RESET; // RULE11 RULE12
    end else if (wr_enables) begin
      enables_q <= bus_in.wdata; // RULE11 RULE12
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & enables_q); // RULE18 RULE8
    end
  end

  // read data is valid in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= ccti_pkg::READ_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus_in.rd;
      rdata_q <= ccti_pkg::READ_ZERO; // RULE5
      if (bus_in.rd) begin
        case (bus_in.addr)
          ccti_pkg::FLAGS_ADDR: rdata_q <= flags_q; // RULE9 RULE10
          ccti_pkg::ENABLES_ADDR: rdata_q <= enables_q; // RULE11
          ccti_pkg::COUNT_LOW_ADDR: rdata_q <= stages[3:0]; // RULE2
          ccti_pkg::COUNT_HIGH_ADDR: rdata_q <= stages[7:4]; // RULE3
          default: rdata_q <= ccti_pkg::READ_ZERO; // RULE5
        endcase
      end
    end
  end

  assign rdata_out = rdata_q;
  assign rvalid_out = rvalid_q;
  assign irq_out = irq_q;

  AST_FLAG_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (|falls) |=> ((flags_q & $past(falls)) == $past(falls))) // RULE7
    else $error("stage edge did not set its flag");
  AST_FLAG_UNMASKED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (falls[ccti_pkg::BIT_1HZ] && !enables_q[ccti_pkg::BIT_1HZ])
    |=> flags_q[ccti_pkg::BIT_1HZ]) // RULE8
    else $error("masked flag was not set");
  AST_READ_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_flags && falls == 4'h0) |=> (flags_q == 4'h0)) // RULE9
    else $error("flag read did not clear the flags");
  AST_SET_WINS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_flags && falls[ccti_pkg::BIT_32HZ]) |=> flags_q[ccti_pkg::BIT_32HZ] ##1
    (!$past(rd_flags) || rdata_out[ccti_pkg::BIT_32HZ])) // RULE17
    else $error("flag set during a read was lost");
  AST_FLAG_READ_VALUE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_flags |=> (rvalid_out && rdata_out == $past(flags_q))) // RULE10
    else $error("flag read returned the wrong value");
  AST_IRQ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ##1 (irq_out == $past(|(flags_q & enables_q)))) // RULE18
    else $error("interrupt request does not follow flags and enables");
  AST_ENABLE_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_enables && !bus_in.rd) |=> ##1 (enables_q == $past(bus_in.wdata, 2) ||
    $past(wr_enables))) // RULE11
    else $error("enable location did not take the written value");
  AST_RESET_READS_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (bus_in.rd && hit(bus_in.addr, ccti_pkg::SOFT_RESET_ADDR)) |=>
    (rdata_out == 4'h0)) // RULE5
    else $error("reset location did not read as zero");
  AST_READ_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (bus_in.rd && hit(bus_in.addr, ccti_pkg::COUNT_LOW_ADDR)) |=>
    (rdata_out == $past(stages[3:0]))) // RULE2
    else $error("low nibble read wrong");
  AST_READ_HIGH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (bus_in.rd && hit(bus_in.addr, ccti_pkg::COUNT_HIGH_ADDR)) |=>
    (rdata_out == $past(stages[7:4]))) // RULE3
    else $error("high nibble read wrong");

  COV_FLAG_SET: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    falls[ccti_pkg::BIT_1HZ] ##1 flags_q[ccti_pkg::BIT_1HZ]);
  COV_READ_CLEAR: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_flags && flags_q != 4'h0) ##1 rvalid_out);
  COV_IRQ: cover property (@(posedge clk_in) disable iff (!rst_n_in) irq_out);
  COV_SOFT_RESET: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    soft_reset ##2 (stages == 8'h00));
endmodule
`default_nettype wire

// file: verif/ccti_timer_tb_top.sv
// self-checking bench for the crystal clock timer top
// assumes the bench owns the slow crystal level and holds it still around reads
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module ccti_timer_tb_top;
  localparam int P = 1;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic xtal = 1'b0;
  ccti_pkg::ccti_bus_req_type bus_in = '0;
  logic [3:0] rdata;
  logic rvalid;
  logic irq;
  logic [P+7:0] cnt, nxt, fall;
  logic [3:0] fl, en, exp_v;
  logic armed;
  logic [3:0] exp_q[$];
  int miscompares = 0;
  int num_checks = 0;

  ccti_timer #(.PRESCALE_BITS(P)) i_dut (
    .clk_in(clk),
    .rst_n_in(rst_n),
    .slow_crystal_clock_in(xtal),
    .bus_in(bus_in),
    .rdata_out(rdata),
    .rvalid_out(rvalid),
    .irq_out(irq)
  );

  always #20 clk = ~clk;

  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    exp_q.push_back(e);
    bus_in.addr = a;
    bus_in.rd = 1'b1;
    @(negedge clk);
    bus_in.rd = 1'b0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    bus_in.addr = a;
    bus_in.wdata = d;
    bus_in.wr = 1'b1;
    @(negedge clk);
    bus_in.wr = 1'b0;
    @(negedge clk);
  endtask

  // one crystal period per step; stage falls feed the flag model
  task automatic step(input int n);
    repeat (n) begin
      xtal = 1'b1;
      nxt = cnt + 1'b1;
      fall = cnt & ~nxt;
      if (armed) begin
        fl[ccti_pkg::BIT_32HZ] |= fall[P+ccti_pkg::STAGE_32HZ];
        fl[ccti_pkg::BIT_16HZ] |= fall[P+ccti_pkg::STAGE_16HZ];
        fl[ccti_pkg::BIT_2HZ] |= fall[P+ccti_pkg::STAGE_2HZ];
        fl[ccti_pkg::BIT_1HZ] |= fall[P+ccti_pkg::STAGE_1HZ];
      end
      cnt = nxt;
      repeat (2) @(negedge clk);
      xtal = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask

  task automatic read_count();
    rd(ccti_pkg::COUNT_LOW_ADDR, cnt[P+3:P]);
    rd(ccti_pkg::COUNT_HIGH_ADDR, cnt[P+7:P+4]);
  endtask

  task automatic soft_reset();
    wr(ccti_pkg::SOFT_RESET_ADDR, 4'h1);
    cnt = '0;
    fl = 4'h0;
    armed = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  // result side: every read answer is matched against the oldest note
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(rdata, 4'hx)
      end else begin
        exp_v = exp_q.pop_front();
        `CHK(rdata, exp_v)
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    void'($urandom(37));
    en = 4'h0;
    fl = 4'h0;
    cnt = '0;
    armed = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rd(ccti_pkg::ENABLES_ADDR, ccti_pkg::ENABLES_RESET);
    rd(ccti_pkg::FLAGS_ADDR, ccti_pkg::FLAGS_RESET);
    soft_reset();
    read_count();
    rd(ccti_pkg::SOFT_RESET_ADDR, ccti_pkg::READ_ZERO);
    rd(8'h00, ccti_pkg::READ_ZERO);
    rd(ccti_pkg::FLAGS_ADDR, fl);
    for (int i = 0; i < 8; i++) begin
      step($urandom_range(1, 120));
      read_count();
      repeat (3) @(negedge clk);
      `CHK(irq, |(fl & en))
      rd(ccti_pkg::FLAGS_ADDR, fl);
      fl = 4'h0;
      rd(ccti_pkg::FLAGS_ADDR, fl);
      en = 4'($urandom_range(0, 15)) | (4'h1 << (i % 4));
      wr(ccti_pkg::ENABLES_ADDR, en);
      rd(ccti_pkg::ENABLES_ADDR, en);
    end
    // read-only places and a zero reset write leave the chain alone
    wr(ccti_pkg::COUNT_LOW_ADDR, 4'hf);
    wr(ccti_pkg::COUNT_HIGH_ADDR, 4'hf);
    wr(ccti_pkg::FLAGS_ADDR, 4'hf);
    wr(ccti_pkg::SOFT_RESET_ADDR, 4'he);
    read_count();
    rd(ccti_pkg::FLAGS_ADDR, fl);
    // system reset mid-run keeps the chain but clears flags and enables
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    armed = 1'b0;
    fl = 4'h0;
    en = 4'h0;
    read_count();
    step(3);
    read_count();
    rd(ccti_pkg::ENABLES_ADDR, ccti_pkg::ENABLES_RESET);
    rd(ccti_pkg::FLAGS_ADDR, ccti_pkg::FLAGS_RESET);
    soft_reset();
    read_count();
    repeat (4) @(negedge clk);
    `CHK(exp_q.size(), 0)
    print_verdict();
  end
endmodule
`default_nettype wire
